/* design/ccsc_regs.vh */
// constants for the card controller system control register (upper half)
// assumes a single 32-bit register reached over axi4-lite at a word offset
`ifndef CCSC_REGS_VH
`define CCSC_REGS_VH
// ========================================
// offsets
`define CCSC_SYSCTL_OFF       8'h80
// ========================================
// field positions
`define CCSC_STEP_HI          31
`define CCSC_STEP_LO          30
`define CCSC_ROUTE_BIT        26
`define CCSC_FLAG_BIT         25
`define CCSC_ENABLE_BIT       24
`define CCSC_RSVD_TERM_BIT    22
`define CCSC_PROT_BIT         21
`define CCSC_ZV_BIT           20
`define CCSC_DREQ_EN_BIT      19
`define CCSC_CHAN_HI          18
`define CCSC_CHAN_LO          16
`define CCSC_BURST_DN_BIT     15
`define CCSC_BURST_UP_BIT     14
`define CCSC_ACT_BIT          13
`define CCSC_RAIL_BIT         12
// ========================================
// reset values
`define CCSC_STEP_RST         2'h0
`define CCSC_CHAN_RST         3'h4
`define CCSC_RSVD_TERM_RST    1'b1
`define CCSC_BURST_DN_RST     1'b1
// ========================================
// axi responses
`define CCSC_RESP_OKAY        2'h0
`define CCSC_RESP_SLVERR      2'h2
`endif

/* design/ccsc_sysctl.v */
// upper half (bits 31..12) of the card controller system control register
// assumes an axi4-lite master on ref_clk; card-side events are synchronous pulses
//
// Functional notes
// - interrupt step field picks serial slot A..D for interrupt line A
// - bits 29..27 read as zero
// - power write raises irq2 pulse when route is 0, status-change pulse when 1
// - management flag sets on socket power write while enable is set
// - writing one to management flag clears it
// - enable set: every socket power write yields a management interrupt; resets 0
// - bit 23 reads as zero
// - reserved-terminal bit 1 drives terminals low with cardbus card, 0 tristates
// - protection bit 0 enables supply protection for 16-bit cards
// - reduced video bit tristates card address lines 25..22
// - dma request enable passes card dma requests, else ignored
// - three-bit dma channel field; default 4 is pci master
// - downstream read burst allowed only while bit set; default 1
// - upstream read burst allowed only while bit set; default 0
// - activity flag sets on card access, clears on read; resets 0
// - bit 12 always reads one
`timescale 1ns/10ps
`include "ccsc_regs.vh"

module ccsc_sysctl (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // socket events from the card side
  input  wire        socket_power_write,
  input  wire        card_access,
  input  wire        card_dma_req,
  input  wire        cardbus_card_present,
  input  wire        card_intr,
  // controls toward the socket and bridge
  output reg  [3:0]  serial_intr_slot,
  output reg         irq2_pulse,
  output reg         card_status_change_intr,
  output reg         mgmt_intr_pulse,
  output reg         reserved_terminal_oe,
  output reg         reserved_terminal_out,
  output reg         supply_protect_en,
  output reg         addr_hi_oe_n,
  output reg         card_dma_request,
  output reg  [2:0]  card_dma_channel,
  output reg         read_burst_dn_allow,
  output reg         read_burst_up_allow
);

  // ========================================
  // storage
  reg [1:0]  serial_intr_slot_step_r;
  reg        mgmt_intr_route_r;
  reg        mgmt_intr_flag_r;
  reg        mgmt_intr_enable_r;
  reg        reserved_terminal_drive_r;
  reg        supply_protect_disable_r;
  reg        reduced_video_port_r;
  reg        card_dma_request_enable_r;
  reg [2:0]  card_dma_channel_r;
  reg        read_burst_downstream_r;
  reg        read_burst_upstream_r;
  reg        socket_activity_flag_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  // two-flop synchronisers for the card pins
  reg        card_dma_req_meta_r;
  reg        card_dma_req_sync_r;
  reg        card_present_meta_r;
  reg        card_present_sync_r;
  reg        card_intr_meta_r;
  reg        card_intr_sync_r;
  // next values of the sticky flags
  reg        mgmt_intr_flag_nxt;
  reg        socket_activity_flag_nxt;

  wire        wr_go;
  wire        rd_go;
  wire        wr_hit;
  wire        rd_hit;
  wire [31:0] rd_word;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        wr_lane3;
  wire        wr_lane2;
  wire        wr_lane1;

  function hit;
    input [7:0] a;
    begin
      hit = (a[7:2] == `CCSC_SYSCTL_OFF >> 2);
    end
  endfunction

  // response code, shared by the write and read channels
  function [1:0] resp_for;
    input [7:0] a;
    begin
      resp_for = hit(a) ? `CCSC_RESP_OKAY : `CCSC_RESP_SLVERR;
    end
  endfunction

  // read data; a miss reads as zero so nothing leaks from other offsets
  function [31:0] rd_value;
    input [7:0]  a;
    input [31:0] word;
    begin
      rd_value = hit(a) ? word : 32'h0000_0000;
    end
  endfunction

  // byte lane write enable; lane 0 belongs to the lower half, never used here
  function lane_we;
    input       go;
    input [3:0] strb;
    input [1:0] lane;
    begin
      lane_we = go & strb[lane];
    end
  endfunction

  // ========================================
  // write channel: address and data taken in either order
  assign wr_addr = s_axi_awready ? s_axi_awaddr : awaddr_r;
  assign wr_data = s_axi_wready ? s_axi_wdata : wdata_r;
  assign wr_strb = s_axi_wready ? s_axi_wstrb : wstrb_r;
  assign wr_go   = (aw_held_r | (s_axi_awvalid & s_axi_awready)) &
                   (w_held_r | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
  assign wr_hit  = wr_go & hit(wr_addr);
  assign wr_lane3 = lane_we(wr_hit, wr_strb, 2'h3);
  assign wr_lane2 = lane_we(wr_hit, wr_strb, 2'h2);
  assign wr_lane1 = lane_we(wr_hit, wr_strb, 2'h1);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCSC_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      // ready only while nothing of that channel is held
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid & ~wr_go;
      s_axi_wready  <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid & ~wr_go;
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_r  <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= resp_for(wr_addr);
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================
  // read channel
  assign rd_go  = s_axi_arvalid & s_axi_arready;
  assign rd_hit = rd_go & hit(s_axi_araddr);

  assign rd_word = {serial_intr_slot_step_r,
                    3'h0,
                    mgmt_intr_route_r,
                    mgmt_intr_flag_r,
                    mgmt_intr_enable_r,
                    1'b0,
                    reserved_terminal_drive_r,
                    supply_protect_disable_r,
                    reduced_video_port_r,
                    card_dma_request_enable_r,
                    card_dma_channel_r,
                    read_burst_downstream_r,
                    read_burst_upstream_r,
                    socket_activity_flag_r,
                    1'b1,
                    12'h000};

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value(s_axi_araddr, rd_word);
        s_axi_rresp  <= resp_for(s_axi_araddr);
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================
  // card pins cross into ref_clk; only the second flop is read
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      card_dma_req_meta_r <= 1'b0;
      card_dma_req_sync_r <= 1'b0;
      card_present_meta_r <= 1'b0;
      card_present_sync_r <= 1'b0;
      card_intr_meta_r    <= 1'b0;
      card_intr_sync_r    <= 1'b0;
    end else begin
      card_dma_req_meta_r <= card_dma_req;
      card_dma_req_sync_r <= card_dma_req_meta_r;
      card_present_meta_r <= cardbus_card_present;
      card_present_sync_r <= card_present_meta_r;
      card_intr_meta_r    <= card_intr;
      card_intr_sync_r    <= card_intr_meta_r;
    end
  end

  // ========================================
  // sticky flags: set beats clear in the same cycle
  always @* begin
    mgmt_intr_flag_nxt       = mgmt_intr_flag_r;
    socket_activity_flag_nxt = socket_activity_flag_r;
    if (socket_power_write & mgmt_intr_enable_r)
      mgmt_intr_flag_nxt = 1'b1;
    else if (wr_lane3 & wr_data[`CCSC_FLAG_BIT])
      mgmt_intr_flag_nxt = 1'b0;
    // new activity in the read cycle survives the clear
    if (card_access)
      socket_activity_flag_nxt = 1'b1;
    else if (rd_hit)
      socket_activity_flag_nxt = 1'b0;
  end

  // ========================================
  // register fields
  // bits 11 and below belong to the lower half and 13..12 are read-only here, so byte 1 only carries 15..14
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_intr_slot_step_r   <= `CCSC_STEP_RST;
      mgmt_intr_route_r         <= 1'b0;
      mgmt_intr_flag_r          <= 1'b0;
      mgmt_intr_enable_r        <= 1'b0;
      reserved_terminal_drive_r <= `CCSC_RSVD_TERM_RST;
      supply_protect_disable_r  <= 1'b0;
      reduced_video_port_r      <= 1'b0;
      card_dma_request_enable_r <= 1'b0;
      card_dma_channel_r        <= `CCSC_CHAN_RST;
      read_burst_downstream_r   <= `CCSC_BURST_DN_RST;
      read_burst_upstream_r     <= 1'b0;
      socket_activity_flag_r    <= 1'b0;
    end else begin
      if (wr_lane3) begin
        serial_intr_slot_step_r <= wr_data[`CCSC_STEP_HI:`CCSC_STEP_LO];
        mgmt_intr_route_r       <= wr_data[`CCSC_ROUTE_BIT];
        mgmt_intr_enable_r      <= wr_data[`CCSC_ENABLE_BIT];
        // reserved bits 29..27 have no storage
      end
      if (wr_lane2) begin
        reserved_terminal_drive_r <= wr_data[`CCSC_RSVD_TERM_BIT];
        supply_protect_disable_r  <= wr_data[`CCSC_PROT_BIT];
        reduced_video_port_r      <= wr_data[`CCSC_ZV_BIT];
        card_dma_request_enable_r <= wr_data[`CCSC_DREQ_EN_BIT];
        card_dma_channel_r        <= wr_data[`CCSC_CHAN_HI:`CCSC_CHAN_LO];
      end
      if (wr_lane1) begin
        read_burst_downstream_r <= wr_data[`CCSC_BURST_DN_BIT];
        read_burst_upstream_r   <= wr_data[`CCSC_BURST_UP_BIT];
        // activity flag is not writable
      end
      mgmt_intr_flag_r       <= mgmt_intr_flag_nxt;
      socket_activity_flag_r <= socket_activity_flag_nxt;
    end
  end

  // ========================================
  // outputs toward the socket
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_intr_slot        <= 4'h0;
      irq2_pulse              <= 1'b0;
      card_status_change_intr <= 1'b0;
      mgmt_intr_pulse         <= 1'b0;
      reserved_terminal_oe    <= 1'b0;
      reserved_terminal_out   <= 1'b0;
      supply_protect_en       <= 1'b1;
      addr_hi_oe_n            <= 1'b0;
      card_dma_request        <= 1'b0;
      card_dma_channel        <= `CCSC_CHAN_RST;
      read_burst_dn_allow     <= 1'b0;
      read_burst_up_allow     <= 1'b0;
    end else begin
      // one-hot slot, line a's interrupt shown in slot a..d
      serial_intr_slot <= {4{card_intr_sync_r}} & (4'h1 << serial_intr_slot_step_r);
      irq2_pulse              <= socket_power_write & ~mgmt_intr_route_r;
      card_status_change_intr <= socket_power_write & mgmt_intr_route_r;
      mgmt_intr_pulse         <= socket_power_write & mgmt_intr_enable_r;
      reserved_terminal_oe    <= reserved_terminal_drive_r & card_present_sync_r;
      reserved_terminal_out   <= 1'b0;
      supply_protect_en       <= ~supply_protect_disable_r;
      addr_hi_oe_n            <= reduced_video_port_r;
      card_dma_request        <= card_dma_req_sync_r & card_dma_request_enable_r;
      card_dma_channel        <= card_dma_channel_r;
      read_burst_dn_allow     <= read_burst_downstream_r;
      read_burst_up_allow     <= read_burst_upstream_r;
    end
  end

endmodule // ccsc_sysctl

/* test/ccsc_sysctl_sva.sv */
// assertions for the system control register block
// sees only top-level ports; bound at the foot of this file
`timescale 1ns/10ps
`include "ccsc_regs.vh"
// ========================================
// checker
module ccsc_sysctl_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // read bus
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // card side
  input wire logic        socket_power_write,
  input wire logic        card_dma_req,
  input wire logic        cardbus_card_present,
  input wire logic        card_intr,
  input wire logic [3:0]  serial_intr_slot,
  input wire logic        irq2_pulse,
  input wire logic        card_status_change_intr,
  input wire logic        mgmt_intr_pulse,
  input wire logic        reserved_terminal_oe,
  input wire logic        reserved_terminal_out,
  input wire logic        card_dma_request
);
  logic hit_r;
  // remembers whether the read under way targets the register
  always @(posedge ref_clk) begin
    if (!rst_n)
      hit_r <= 1'h0;
    else if (s_axi_arvalid && s_axi_arready)
      hit_r <= (s_axi_araddr == `CCSC_SYSCTL_OFF);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // card pins pass a two-flop synchroniser, so their effect shows three edges later
  a_slot_onehot: assert property ($onehot0(serial_intr_slot))
    else $error("slot not one-hot");
  a_slot_cause: assert property (|serial_intr_slot |-> $past(card_intr, 3))
    else $error("slot without interrupt");
  a_route_one: assert property (socket_power_write |=> irq2_pulse != card_status_change_intr)
    else $error("power write routing");
  a_route_cause: assert property (
    (irq2_pulse || card_status_change_intr) |-> $past(socket_power_write))
    else $error("route pulse without write");
  a_mgmt_cause: assert property (mgmt_intr_pulse |-> $past(socket_power_write))
    else $error("mgmt pulse without write");
  a_term_drive: assert property (
    reserved_terminal_oe |-> $past(cardbus_card_present, 3) && !reserved_terminal_out)
    else $error("terminal drive");
  a_dma_gate: assert property (card_dma_request |-> $past(card_dma_req, 3))
    else $error("dma request without card");
  a_rsvd_read: assert property (s_axi_rvalid && hit_r |->
    s_axi_rdata[29:27] == 3'h0 && !s_axi_rdata[23] && s_axi_rdata[12])
    else $error("reserved bits");
endmodule // ccsc_sysctl_sva

bind ccsc_sysctl ccsc_sysctl_sva u_sva (.ref_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .socket_power_write, .card_dma_req, .cardbus_card_present, .card_intr,
  .serial_intr_slot, .irq2_pulse, .card_status_change_intr, .mgmt_intr_pulse, .reserved_terminal_oe,
  .reserved_terminal_out, .card_dma_request);

/* test/ccsc_card_model.sv */
// card-side event source for the register block
// assumes its tasks are called from the bench's main sequence
`timescale 1ns/10ps
// ========================================
// card model
module ccsc_card_model (
  // clock
  input  wire logic ref_clk,
  // events toward the block
  output logic      socket_power_write,
  output logic      card_access
);
  initial begin
    socket_power_write = 1'h0;
    card_access        = 1'h0;
  end
  // single-cycle strobe, one per software power write
  task power_write;
    @(posedge ref_clk) socket_power_write <= 1'h1;
    @(posedge ref_clk) socket_power_write <= 1'h0;
  endtask
  task access;
    @(posedge ref_clk) card_access <= 1'h1;
    @(posedge ref_clk) card_access <= 1'h0;
  endtask
endmodule // ccsc_card_model

/* test/test_card_controller_system_control_hi.sv */
// self-checking bench for the system control register block
// axi4-lite master tasks, card model events, one 40 MHz clock
`timescale 1ns/10ps
`include "ccsc_regs.vh"
// ========================================
// bench
module test_card_controller_system_control_hi;
  logic        ref_clk = 1'h0, rst_n = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, card_dma_req = 1'h0, cardbus_card_present = 1'h0, card_intr = 1'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         socket_power_write, card_access, irq2_pulse, card_status_change_intr, mgmt_intr_pulse;
  wire         reserved_terminal_oe, reserved_terminal_out, supply_protect_en, addr_hi_oe_n;
  wire         card_dma_request, read_burst_dn_allow, read_burst_up_allow;
  wire  [3:0]  serial_intr_slot;
  wire  [2:0]  card_dma_channel;
  int          n_mismatch = 0, num_checks = 0, n_irq2 = 0, n_csc = 0, n_mgmt = 0;
  always #12.5 ref_clk = ~ref_clk;
  ccsc_card_model u_card (.ref_clk, .socket_power_write, .card_access);
  ccsc_sysctl u_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .socket_power_write, .card_access, .card_dma_req, .cardbus_card_present, .card_intr, .serial_intr_slot,
    .irq2_pulse, .card_status_change_intr, .mgmt_intr_pulse, .reserved_terminal_oe, .reserved_terminal_out,
    .supply_protect_en, .addr_hi_oe_n, .card_dma_request, .card_dma_channel, .read_burst_dn_allow,
    .read_burst_up_allow);
  // pulses are counted rather than caught, so no edge is missed
  always @(posedge ref_clk) if (rst_n) begin
    n_irq2 += irq2_pulse;
    n_csc += card_status_change_intr;
    n_mgmt += mgmt_intr_pulse;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  function automatic logic [31:0] ctl();
    return {25'h0, supply_protect_en, addr_hi_oe_n, card_dma_channel, read_burst_dn_allow, read_burst_up_allow};
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    rdc(8'h84, 32'h0, `CCSC_RESP_SLVERR);
    wr(8'h84, 32'hffff_ffff, `CCSC_RESP_SLVERR);
    rdc(`CCSC_SYSCTL_OFF, 32'h0044_9000, `CCSC_RESP_OKAY);
    chk("ctl", 32'h52, ctl());
    wr(`CCSC_SYSCTL_OFF, 32'hffff_ffff, `CCSC_RESP_OKAY);
    rdc(`CCSC_SYSCTL_OFF, 32'hc57f_d000, `CCSC_RESP_OKAY);
    chk("ctl", 32'h3f, ctl());
    card_dma_req <= 1'h1;
    cardbus_card_present <= 1'h1;
    card_intr <= 1'h1;
    u_card.power_write();
    repeat (3) @(posedge ref_clk);
    // step code 3 puts line a's interrupt in slot d, the top bit
    chk("pins", 32'h1c, {27'h0, card_dma_request, reserved_terminal_oe, serial_intr_slot[3:1]});
    chk("counts", 32'h0101, {8'h0, n_irq2[7:0], n_csc[7:0], n_mgmt[7:0]});
    rdc(`CCSC_SYSCTL_OFF, 32'hc77f_d000, `CCSC_RESP_OKAY);
    wr(`CCSC_SYSCTL_OFF, 32'hffff_ffff, `CCSC_RESP_OKAY);
    rdc(`CCSC_SYSCTL_OFF, 32'hc57f_d000, `CCSC_RESP_OKAY);
    // every slot step code, with the drive and request bits cleared
    for (int c = 0; c < 4; c++) begin
      wr(`CCSC_SYSCTL_OFF, {c[1:0], 30'h0}, `CCSC_RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      chk("slot", 32'h1 << c, {28'h0, serial_intr_slot});
      chk("gates", 32'h0, {30'h0, card_dma_request, reserved_terminal_oe});
    end
    u_card.power_write();
    repeat (3) @(posedge ref_clk);
    chk("counts", 32'h010101, {8'h0, n_irq2[7:0], n_csc[7:0], n_mgmt[7:0]});
    rdc(`CCSC_SYSCTL_OFF, 32'hc000_1000, `CCSC_RESP_OKAY);
    u_card.access();
    rdc(`CCSC_SYSCTL_OFF, 32'hc000_3000, `CCSC_RESP_OKAY);
    rdc(`CCSC_SYSCTL_OFF, 32'hc000_1000, `CCSC_RESP_OKAY);
    close_out();
  end
endmodule // test_card_controller_system_control_hi
